// file: dv/apio_plc_model.sv
`timescale 1ns/1ns
`default_nettype none
module apio_plc_model #(
	// spacing cut from 2 ms so the run stays short
	parameter int unsigned SPACE_CYC = 20
) (
	input wire logic sys_clk_i,
	input wire logic alarm_n_i,
	output logic [3:0] step_select_o,
	output logic drive_o,
	output logic servo_enable_o
);
	initial begin
		step_select_o = 4'h0;
		drive_o = 1'b0;
		servo_enable_o = 1'b0;
	end
	// step bits settle before drive moves, so the step is stable when sampled
	task automatic apply(input logic [3:0] step, input logic drv, input logic servo);
		int n;
		n = 0;
		while (servo && !servo_enable_o && alarm_n_i !== 1'b1 && n < 1000) begin
			@(posedge sys_clk_i);
			n++;
		end
		if (n >= 1000) begin
			test_apio_top.chk("alarm before servo", 32'h0000_0001, 32'h0000_0000);
			test_apio_top.tally_and_finish();
		end
		@(posedge sys_clk_i);
		step_select_o <= step;
		servo_enable_o <= servo;
		repeat (SPACE_CYC) @(posedge sys_clk_i);
		drive_o <= drv;
		repeat (SPACE_CYC) @(posedge sys_clk_i);
	endtask : apply
endmodule : apio_plc_model
`default_nettype wire

// file: dv/test_apio_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_apio_top;
	logic sys_clk, rst_n, reg_wr, reg_rd, step_done, fault;
	logic [7:0] reg_addr, force_v, current, temp;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] position;
	logic [3:0] step_sel, step_num;
	logic drive, servo, m_start, m_stop, m_power, busy, alarm_n, out_a, out_b;
	int mismatches, num_checks;
	apio_top dut_u (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.step_select_i(step_sel), .drive_i(drive), .servo_enable_i(servo),
		.step_done_i(step_done), .fault_i(fault), .position_i(position), .force_i(force_v),
		.current_i(current), .temp_i(temp), .motion_start_o(m_start), .motion_stop_o(m_stop),
		.step_num_o(step_num), .motor_power_o(m_power), .busy_o(busy), .alarm_n_o(alarm_n),
		.general_output_a_o(out_a), .general_output_b_o(out_b));
	apio_plc_model plc_u (.sys_clk_i(sys_clk), .alarm_n_i(alarm_n), .step_select_o(step_sel),
		.drive_o(drive), .servo_enable_o(servo));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(what, exp, d);
	endtask : rdchk
	task automatic meas(input logic [15:0] p, input logic [7:0] f, c, t);
		@(posedge sys_clk);
		position <= p;
		force_v <= f;
		current <= c;
		temp <= t;
	endtask : meas
	// bounded wait; a lost start ends the run rather than hanging
	task automatic wait_start(input logic want, input logic [3:0] step);
		int n;
		n = 0;
		while (m_start !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk("start", {31'h0, want}, {31'h0, n < 100});
		if (want && n < 100) begin
			chk("step_num", {28'h0, step}, {28'h0, step_num});
			chk("busy", 32'h0000_0001, {31'h0, busy});
		end
		if (want && n >= 100) tally_and_finish();
	endtask : wait_start
	// bounded wait for the one-cycle stop pulse
	task automatic wait_stop();
		int n;
		n = 0;
		while (m_stop !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk("stop", 32'h0000_0001, {31'h0, n < 100});
		if (n >= 100) tally_and_finish();
	endtask : wait_stop
	task automatic finish_step();
		@(posedge sys_clk);
		step_done <= 1'b1;
		@(posedge sys_clk);
		step_done <= 1'b0;
		cyc(3);
	endtask : finish_step
	task automatic t_reset();
		rdchk("thresh", apio_pkg::IDX_THRESH, 32'h0046_1E07);
		rdchk("outsel", apio_pkg::IDX_OUTSEL, 32'h0000_0010);
		rdchk("ctrl", apio_pkg::IDX_CTRL, 32'h0000_0000);
		rdchk("unmapped", 8'h3F, 32'h0000_0000);
		chk("alarm_n idle", 32'h0000_0001, {31'h0, alarm_n});
		$display("done reset");
	endtask : t_reset
	task automatic t_inputs();
		logic [5:0] pat [3] = '{6'h05, 6'h1A, 6'h23};
		for (int i = 0; i < 3; i++) begin
			plc_u.apply(pat[i][3:0], pat[i][4], pat[i][5]);
			rdchk("inputs", apio_pkg::IDX_INPUTS, {26'h0, pat[i]});
		end
		plc_u.apply(4'h0, 1'b0, 1'b0);
		$display("done inputs");
	endtask : t_inputs
	task automatic t_monitor();
		wr(apio_pkg::IDX_CTRL, 32'h0000_0001);
		plc_u.apply(4'h0, 1'b0, 1'b1);
		fork
			plc_u.apply(4'h0, 1'b1, 1'b1);
			wait_start(1'b1, 4'h0);
		join
		finish_step();
		chk("busy home", 32'h0, {31'h0, busy});
		plc_u.apply(4'hA, 1'b0, 1'b1);
		fork
			plc_u.apply(4'hA, 1'b1, 1'b1);
			wait_start(1'b1, 4'hA);
		join
		finish_step();
		chk("busy done", 32'h0, {31'h0, busy});
		plc_u.apply(4'h5, 1'b0, 1'b1);
		fork
			plc_u.apply(4'h5, 1'b1, 1'b1);
			wait_start(1'b1, 4'h5);
		join
		fork
			plc_u.apply(4'h5, 1'b0, 1'b1);
			wait_stop();
		join
		cyc(1);
		chk("busy stop", 32'h0, {31'h0, busy});
		plc_u.apply(4'h0, 1'b0, 1'b0);
		wr(apio_pkg::IDX_CTRL, 32'h0000_0000);
		$display("done monitor");
	endtask : t_monitor
	task automatic t_testmode();
		wr(apio_pkg::IDX_SWCMD, 32'h0000_0001);
		wait_start(1'b1, 4'h0);
		finish_step();
		fork
			plc_u.apply(4'h3, 1'b1, 1'b1);
			wait_start(1'b0, 4'h0);
		join
		wr(apio_pkg::IDX_SWCMD, 32'h0000_0061);
		wait_start(1'b1, 4'h6);
		wr(apio_pkg::IDX_SWCMD, 32'h0000_0002);
		wait_stop();
		cyc(3);
		chk("busy sw stop", 32'h0, {31'h0, busy});
		plc_u.apply(4'h0, 1'b0, 1'b0);
		$display("done testmode");
	endtask : t_testmode
	task automatic t_thresh();
		logic [7:0] v [4] = '{8'h04, 8'h28, 8'h05, 8'h27};
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			wr(apio_pkg::IDX_THRESH, {16'h0046, 8'h1E, v[i]});
			rdchk("thresh", apio_pkg::IDX_THRESH, {16'h0046, 8'h1E, i < 2 ? 8'h07 : v[i]});
			rd(apio_pkg::IDX_STATUS, d);
			chk("reject", {31'h0, i < 2}, {31'h0, d[3]});
			wr(apio_pkg::IDX_STATUS, 32'h0000_0008);
		end
		wr(apio_pkg::IDX_THRESH, 32'h0046_1E07);
		$display("done thresh");
	endtask : t_thresh
	// each source driven active (windows mid-range, thresholds one count over), then at its idle value
	task automatic t_flags();
		wr(apio_pkg::IDX_INPOS, 32'h0200_0100);
		wr(apio_pkg::IDX_AREA_A, 32'h3000_2000);
		wr(apio_pkg::IDX_AREA_B, 32'h5000_4000);
		for (int s = 0; s < 6; s++) begin
			wr(apio_pkg::IDX_OUTSEL, {24'h0, s[3:0], s[3:0]});
			meas(s == 0 ? 16'h0150 : s == 2 ? 16'h2800 : s == 3 ? 16'h4800 : 16'h0000,
				s == 1 ? 8'h08 : 8'h07, s == 4 ? 8'h1F : 8'h1E, s == 5 ? 8'h47 : 8'h46);
			cyc(4);
			chk("flag set", 32'h0000_0003, {30'h0, out_b, out_a});
			meas(16'h0000, 8'h07, 8'h1E, 8'h46);
			cyc(4);
			chk("flag clear", 32'h0, {30'h0, out_b, out_a});
		end
		$display("done flags");
	endtask : t_flags
	task automatic t_override();
		wr(apio_pkg::IDX_CTRL, 32'h0000_0002);
		for (int i = 0; i < 2; i++) begin
			wr(apio_pkg::IDX_FORCE, {24'h0, 4'hF, i ? 4'hA : 4'h5});
			cyc(3);
			chk("override", {28'h0, i ? 4'hA : 4'h5}, {28'h0, out_b, out_a, alarm_n, busy});
		end
		wr(apio_pkg::IDX_CTRL, 32'h0000_0000);
		$display("done override");
	endtask : t_override
	task automatic t_fault();
		wr(apio_pkg::IDX_SWCMD, 32'h0000_0031);
		wait_start(1'b1, 4'h3);
		@(posedge sys_clk);
		fault <= 1'b1;
		wait_stop();
		cyc(3);
		chk("fault outs", 32'h0, {29'h0, m_power, alarm_n, busy});
		@(posedge sys_clk);
		fault <= 1'b0;
		cyc(3);
		chk("recovered", 32'h0000_0006, {29'h0, m_power, alarm_n, busy});
		wr(apio_pkg::IDX_CTRL, 32'h0000_0004);
		cyc(3);
		chk("sw fault", 32'h0, {30'h0, m_power, alarm_n});
		wr(apio_pkg::IDX_CTRL, 32'h0000_0000);
		$display("done fault");
	endtask : t_fault
	initial begin
		mismatches = 0;
		num_checks = 0;
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		step_done = 1'b0;
		fault = 1'b0;
		position = 16'h0000;
		force_v = 8'h00;
		current = 8'h00;
		temp = 8'h00;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_inputs();
		t_monitor();
		t_testmode();
		t_thresh();
		t_flags();
		t_override();
		t_fault();
		tally_and_finish();
	end
endmodule : test_apio_top
`default_nettype wire

// file: include/apio_pkg.sv
`default_nettype none
package apio_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	// register index map, byte address = index * 4
	localparam logic [7:0] IDX_CTRL = 8'h00;
	localparam logic [7:0] IDX_OUTSEL = 8'h01;
	localparam logic [7:0] IDX_FORCE = 8'h02;
	localparam logic [7:0] IDX_INPOS = 8'h03;
	localparam logic [7:0] IDX_AREA_A = 8'h04;
	localparam logic [7:0] IDX_AREA_B = 8'h05;
	localparam logic [7:0] IDX_THRESH = 8'h06;
	localparam logic [7:0] IDX_SWCMD = 8'h07;
	localparam logic [7:0] IDX_STATUS = 8'h08;
	localparam logic [7:0] IDX_INPUTS = 8'h09;
	localparam logic [7:0] IDX_POS = 8'h0A;
	localparam logic [7:0] IDX_MEAS = 8'h0B;
	// ctrl field positions
	localparam int unsigned CTRL_MONITOR = 0;
	localparam int unsigned CTRL_MANUAL = 1;
	localparam int unsigned CTRL_FAULT = 2;
	// force register: [3:0] value, [7:4] override enable; bit order busy, alarm, a, b
	localparam int unsigned OUT_BUSY = 0;
	localparam int unsigned OUT_ALARM = 1;
	localparam int unsigned OUT_A = 2;
	localparam int unsigned OUT_B = 3;
	// software command register fields
	localparam int unsigned SW_START = 0;
	localparam int unsigned SW_STOP = 1;
	localparam int unsigned SW_STEP_LSB = 4;
	// status bits
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_POWER = 1;
	localparam int unsigned ST_ALARM = 2;
	localparam int unsigned ST_REJECT = 3;
	localparam int unsigned ST_STEP_LSB = 4;
	// force-band threshold in tenths: 0.5 .. 3.9, step 0.1
	localparam logic [7:0] FB_MIN = 8'h05;
	localparam logic [7:0] FB_MAX = 8'h27;
	localparam logic [7:0] FB_RESET = 8'h07;
	localparam logic [7:0] OC_RESET = 8'h1E;
	localparam logic [7:0] OT_RESET = 8'h46;
	localparam logic [3:0] OUTSEL_A_RESET = 4'h0;
	localparam logic [3:0] OUTSEL_B_RESET = 4'h1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// input change spacing time and its cycle count
	localparam int unsigned IN_HOLD_US = 2000;
	localparam int unsigned IN_HOLD_CYC = IN_HOLD_US * (CLK_HZ / 1_000_000);

	typedef enum logic [3:0] {
		APIO_SRC_INPOS = 4'h0,
		APIO_SRC_FORCE = 4'h1,
		APIO_SRC_AREA_A = 4'h2,
		APIO_SRC_AREA_B = 4'h3,
		APIO_SRC_OVC = 4'h4,
		APIO_SRC_OVT = 4'h5
	} apio_src_e;

	typedef struct packed {
		logic servo_enable;
		logic drive;
		logic [3:0] step_select;
	} apio_cmd_s;

	typedef struct packed {
		logic in_position_flag;
		logic force_band_flag;
		logic area_a_flag;
		logic area_b_flag;
		logic overcurrent_flag;
		logic overtemp_flag;
	} apio_flags_s;
endpackage : apio_pkg
`default_nettype wire

// file: rtl/apio_in_sync.sv
`timescale 1ns/1ns
`default_nettype none
module apio_in_sync (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// pin side
	input wire logic [5:0] pin_i,
	// clean side
	output logic [5:0] level_o
);
	logic [5:0] s1_q, s2_q, s3_q, lvl_q;
	logic [5:0] s1_d, s2_d, s3_d, lvl_d;

	always_comb begin
		s1_d = pin_i;
		s2_d = s1_q;
		s3_d = s2_q;
		// accept a change once the second and third stages agree
		lvl_d = lvl_q;
		for (int i = 0; i < 6; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				lvl_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= 6'h00;
			s2_q <= 6'h00;
			s3_q <= 6'h00;
			lvl_q <= 6'h00;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			lvl_q <= lvl_d;
		end
	end

	assign level_o = lvl_q;
endmodule : apio_in_sync
`default_nettype wire

// file: rtl/apio_top.sv
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module apio_top (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// parallel inputs from controller
	input wire logic [3:0] step_select_i,
	input wire logic drive_i,
	input wire logic servo_enable_i,
	// motion core side
	input wire logic step_done_i,
	input wire logic fault_i,
	input wire logic [15:0] position_i,
	input wire logic [7:0] force_i,
	input wire logic [7:0] current_i,
	input wire logic [7:0] temp_i,
	output logic motion_start_o,
	output logic motion_stop_o,
	output logic [3:0] step_num_o,
	output logic motor_power_o,
	// parallel outputs to controller
	output logic busy_o,
	output logic alarm_n_o,
	output logic general_output_a_o,
	output logic general_output_b_o
);
	typedef enum logic [2:0] {
		APIO_IDLE = 3'b001,
		APIO_RUN = 3'b010,
		APIO_FAULT = 3'b100
	} apio_state_e;

	function automatic logic in_win(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		in_win = (v >= lo) && (v <= hi);
	endfunction : in_win

	function automatic logic pick_src(input logic [3:0] sel, input apio_pkg::apio_flags_s f);
		unique case (sel)
			apio_pkg::APIO_SRC_INPOS: pick_src = f.in_position_flag;
			apio_pkg::APIO_SRC_FORCE: pick_src = f.force_band_flag;
			apio_pkg::APIO_SRC_AREA_A: pick_src = f.area_a_flag;
			apio_pkg::APIO_SRC_AREA_B: pick_src = f.area_b_flag;
			apio_pkg::APIO_SRC_OVC: pick_src = f.overcurrent_flag;
			apio_pkg::APIO_SRC_OVT: pick_src = f.overtemp_flag;
			default: pick_src = 1'b0;
		endcase
	endfunction : pick_src

	logic [5:0] pin_lvl;
	apio_pkg::apio_cmd_s cmd;

	apio_in_sync u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i({servo_enable_i, drive_i, step_select_i}),
		.level_o(pin_lvl)
	);
	assign cmd = apio_pkg::apio_cmd_s'(pin_lvl);

	// configuration registers
	logic [2:0] ctrl_q, ctrl_d;
	logic [7:0] outsel_q, outsel_d;
	logic [7:0] force_q, force_d;
	logic [31:0] inpos_q, inpos_d, area_a_q, area_a_d, area_b_q, area_b_d;
	logic [23:0] thr_q, thr_d;
	logic reject_q, reject_d;
	logic sw_start, sw_stop;
	logic [3:0] sw_step;
	logic [31:0] rdata_q, rdata_d;
	apio_state_e state_q, state_d;
	logic [3:0] step_q, step_d;
	logic drive_prev_q, drive_prev_d;
	logic start_q, start_d, stop_q, stop_d;
	apio_pkg::apio_flags_s flags_q, flags_d;
	logic [3:0] out_q, out_d;
	logic monitor;
	logic power_q, power_d;
	logic [7:0] fb_new;

	assign monitor = ctrl_q[apio_pkg::CTRL_MONITOR];
	assign fb_new = reg_wdata_i[7:0];

	always_comb begin
		ctrl_d = ctrl_q;
		outsel_d = outsel_q;
		force_d = force_q;
		inpos_d = inpos_q;
		area_a_d = area_a_q;
		area_b_d = area_b_q;
		thr_d = thr_q;
		reject_d = reject_q;
		sw_start = 1'b0;
		sw_stop = 1'b0;
		sw_step = reg_wdata_i[apio_pkg::SW_STEP_LSB +: 4];
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				apio_pkg::IDX_CTRL: ctrl_d = reg_wdata_i[2:0];
				apio_pkg::IDX_OUTSEL: outsel_d = reg_wdata_i[7:0];
				apio_pkg::IDX_FORCE: force_d = reg_wdata_i[7:0];
				apio_pkg::IDX_INPOS: inpos_d = reg_wdata_i;
				apio_pkg::IDX_AREA_A: area_a_d = reg_wdata_i;
				apio_pkg::IDX_AREA_B: area_b_d = reg_wdata_i;
				apio_pkg::IDX_THRESH: begin
					// out-of-range band value: whole write dropped, sticky flag set
					if (fb_new >= apio_pkg::FB_MIN && fb_new <= apio_pkg::FB_MAX) begin
						thr_d = reg_wdata_i[23:0];
					end else begin
						reject_d = 1'b1;
					end
				end
				apio_pkg::IDX_SWCMD: begin
					sw_start = reg_wdata_i[apio_pkg::SW_START];
					sw_stop = reg_wdata_i[apio_pkg::SW_STOP];
				end
				apio_pkg::IDX_STATUS: begin
					if (reg_wdata_i[apio_pkg::ST_REJECT]) begin
						reject_d = 1'b0;
					end
				end
				// unmapped writes are ignored
				default: ctrl_d = ctrl_q;
			endcase
		end
	end

	// register read path, unmapped reads zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				apio_pkg::IDX_CTRL: rdata_d = {29'h0000_0000, ctrl_q};
				apio_pkg::IDX_OUTSEL: rdata_d = {24'h00_0000, outsel_q};
				apio_pkg::IDX_FORCE: rdata_d = {24'h00_0000, force_q};
				apio_pkg::IDX_INPOS: rdata_d = inpos_q;
				apio_pkg::IDX_AREA_A: rdata_d = area_a_q;
				apio_pkg::IDX_AREA_B: rdata_d = area_b_q;
				apio_pkg::IDX_THRESH: rdata_d = {8'h00, thr_q};
				apio_pkg::IDX_STATUS: rdata_d = {24'h00_0000, step_q,
					reject_q, state_q == APIO_FAULT, motor_power_o, busy_o};
				apio_pkg::IDX_INPUTS: rdata_d = {26'h000_0000, pin_lvl};
				apio_pkg::IDX_POS: rdata_d = {16'h0000, position_i};
				apio_pkg::IDX_MEAS: rdata_d = {8'h00, temp_i, current_i, force_i};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// motion sequencer
	always_comb begin
		state_d = state_q;
		step_d = step_q;
		start_d = 1'b0;
		stop_d = 1'b0;
		drive_prev_d = cmd.drive;
		unique case (state_q)
			APIO_IDLE: begin
				if (monitor && cmd.servo_enable && cmd.drive && !drive_prev_q) begin
					step_d = cmd.step_select;
					start_d = 1'b1;
					state_d = APIO_RUN;
				end else if (!monitor && sw_start) begin
					step_d = sw_step;
					start_d = 1'b1;
					state_d = APIO_RUN;
				end
			end
			APIO_RUN: begin
				if (step_done_i) begin
					state_d = APIO_IDLE;
				end else if ((monitor && (!cmd.drive || !cmd.servo_enable))
					|| (!monitor && sw_stop)) begin
					stop_d = 1'b1;
					state_d = APIO_IDLE;
				end
			end
			APIO_FAULT: begin
				// leave only once fault gone and servo dropped
				if (!fault_i && !cmd.servo_enable) begin
					state_d = APIO_IDLE;
				end
			end
			default: state_d = APIO_FAULT;
		endcase
		if (fault_i || ctrl_q[apio_pkg::CTRL_FAULT]) begin
			state_d = APIO_FAULT;
			start_d = 1'b0;
			stop_d = state_q == APIO_RUN;
		end
	end

	// flags and output mux
	always_comb begin
		flags_d.in_position_flag = in_win(position_i, inpos_q[15:0], inpos_q[31:16]);
		flags_d.force_band_flag = force_i > thr_q[7:0];
		flags_d.area_a_flag = in_win(position_i, area_a_q[15:0], area_a_q[31:16]);
		flags_d.area_b_flag = in_win(position_i, area_b_q[15:0], area_b_q[31:16]);
		flags_d.overcurrent_flag = current_i > thr_q[15:8];
		flags_d.overtemp_flag = temp_i > thr_q[23:16];
		out_d[apio_pkg::OUT_BUSY] = state_d == APIO_RUN;
		out_d[apio_pkg::OUT_ALARM] = state_d != APIO_FAULT;
		// registered, not decoded, so the power enable cannot glitch
		power_d = state_d != APIO_FAULT;
		out_d[apio_pkg::OUT_A] = pick_src(outsel_q[3:0], flags_q);
		out_d[apio_pkg::OUT_B] = pick_src(outsel_q[7:4], flags_q);
		// override sits last so a connection check beats live state
		if (ctrl_q[apio_pkg::CTRL_MANUAL]) begin
			for (int i = 0; i < 4; i++) begin
				if (force_q[4 + i]) begin
					out_d[i] = force_q[i];
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= {1'b0, apio_pkg::CTRL_RESET};
			outsel_q <= {apio_pkg::OUTSEL_B_RESET, apio_pkg::OUTSEL_A_RESET};
			force_q <= 8'h00;
			inpos_q <= 32'h0000_0000;
			area_a_q <= 32'h0000_0000;
			area_b_q <= 32'h0000_0000;
			thr_q <= {apio_pkg::OT_RESET, apio_pkg::OC_RESET, apio_pkg::FB_RESET};
			reject_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			state_q <= APIO_IDLE;
			step_q <= 4'h0;
			drive_prev_q <= 1'b0;
			start_q <= 1'b0;
			stop_q <= 1'b0;
			flags_q <= '0;
			out_q <= 4'h0;
			power_q <= 1'b1;
		end else begin
			ctrl_q <= ctrl_d;
			outsel_q <= outsel_d;
			force_q <= force_d;
			inpos_q <= inpos_d;
			area_a_q <= area_a_d;
			area_b_q <= area_b_d;
			thr_q <= thr_d;
			reject_q <= reject_d;
			rdata_q <= rdata_d;
			state_q <= state_d;
			step_q <= step_d;
			drive_prev_q <= drive_prev_d;
			start_q <= start_d;
			stop_q <= stop_d;
			flags_q <= flags_d;
			out_q <= out_d;
			power_q <= power_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign motion_start_o = start_q;
	assign motion_stop_o = stop_q;
	assign step_num_o = step_q;
	assign motor_power_o = power_q;
	assign busy_o = out_q[apio_pkg::OUT_BUSY];
	assign alarm_n_o = out_q[apio_pkg::OUT_ALARM];
	assign general_output_a_o = out_q[apio_pkg::OUT_A];
	assign general_output_b_o = out_q[apio_pkg::OUT_B];

	// assertions
	sequence s_fault_seen;
		fault_i;
	endsequence
	a_fault_drops_power: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_fault_seen |=> !motor_power_o && !motion_start_o)
		else $error("motor power not removed on fault");
	a_alarm_follows_fault: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(fault_i && !ctrl_q[apio_pkg::CTRL_MANUAL]) |=> !alarm_n_o)
		else $error("alarm output not low on fault");
	a_test_ignores_pins: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_q == APIO_IDLE && !monitor && !sw_start) |=> !motion_start_o)
		else $error("start in test mode without software command");
	a_monitor_drive_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_q == APIO_IDLE && monitor && cmd.servo_enable && cmd.drive && !drive_prev_q
		&& !fault_i && !ctrl_q[apio_pkg::CTRL_FAULT]) |=> motion_start_o
		&& step_num_o == $past(cmd.step_select))
		else $error("drive edge did not start selected step");
	a_busy_tracks_run: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!ctrl_q[apio_pkg::CTRL_MANUAL] |=> busy_o == (state_q == APIO_RUN))
		else $error("busy not matching run state");
	a_band_reject: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_wr_i && reg_addr_i == apio_pkg::IDX_THRESH && fb_new > apio_pkg::FB_MAX)
		|=> reject_q && thr_q[7:0] == $past(thr_q[7:0]))
		else $error("bad band threshold accepted");
	a_area_a_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$stable(area_a_q) |=> flags_q.area_a_flag
		== in_win($past(position_i), $past(area_a_q[15:0]), $past(area_a_q[31:16])))
		else $error("area a flag wrong");
	a_override_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(ctrl_q[apio_pkg::CTRL_MANUAL] && force_q[4 + apio_pkg::OUT_A])
		|=> general_output_a_o == $past(force_q[apio_pkg::OUT_A]))
		else $error("manual override of output a ignored");
endmodule : apio_top
`default_nettype wire
